// File: core/hsp_fifo.sv
// Purpose: small valid/ready fifo in flip-flops
// Assumes: DEPTH is a power of two
// Notes:   no read-through; a push into an empty fifo shows next cycle
`timescale 1ns/1ns
module hsp_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_ff [DEPTH];
   logic [W-1:0]  nxt_mem [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0]   cnt_ff, nxt_cnt;
   logic          push, pop;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rd_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      nxt_mem = mem_ff;
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wr_ff] = in_data;
         nxt_wr         = wr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rd = rd_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         mem_ff <= nxt_mem;
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

// File: core/hsp_host_serial_port.sv
// Purpose: host serial port with AXI4-Lite register access
// Assumes: 10 MHz mclk, host keeps the same rate and frame
// Notes:   no modem handshakes; tx writes stall while the fifo is full
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns

// What this block does
// - the port runs at 9600, 19200 or 38400 bit/s as chosen by the speed register.
// - a written speed drives the bit clock at once with no apply step.
// - every character is eight data bits, no parity and one stop bit, fixed.
// - characters move with no flow control of any kind.
// - while fixed_settings_mode is high the port runs at 9600 bit/s whatever is programmed.
// - receive data, transmit data and ground carry the link; dtr_out and rts_out are held high; modem status inputs are absent.
module hsp_host_serial_port
   import hsp_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              rxd_pin,
   output logic                   txd_pin,
   output logic                   dtr_out,
   output logic                   rts_out,
   input  wire logic              fixed_settings_mode
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic              aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
   logic [ADDR_W-1:0] awa_ff, nxt_awa;
   logic [31:0]       wd_ff, nxt_wd;
   logic              ws0_ff, nxt_ws0;
   logic              bv_ff, nxt_bv, rv_ff, nxt_rv;
   logic [1:0]        br_ff, nxt_br, rr_ff, nxt_rr;
   logic [31:0]       rd_ff, nxt_rd;
   hsp_speed_t        spd_ff, nxt_spd, eff_spd;
   logic [7:0]        rxb_ff, nxt_rxb;
   logic              rxv_ff, nxt_rxv, ovr_ff, nxt_ovr, fer_ff, nxt_fer;
   logic              m1_ff, m2_ff;
   logic [DIV_W-1:0]  div_ff, nxt_div, div_sel;
   logic              tick_ff, nxt_tick;
   hsp_line_t         tst_ff, nxt_tst;
   logic [3:0]        tos_ff, nxt_tos;
   logic [2:0]        tbit_ff, nxt_tbit;
   logic [7:0]        tsh_ff, nxt_tsh;
   logic              txd_ff, nxt_txd;
   logic              wr_both, is_tx, tx_stall, do_wr, do_rd;
   logic              f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [7:0]        f_out_data;
   logic [31:0]       status_w;

   hsp_rx_if rif ();

   // ---------------------------------------------------------------
   // submodules
   // ---------------------------------------------------------------
   hsp_fifo #(
      .W     (8),
      .DEPTH (TX_FIFO_DEPTH)
   ) u_txfifo (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (wd_ff[7:0]),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   hsp_rx u_rx (
      .mclk    (mclk),
      .reset_n (reset_n),
      .rxd_pin (rxd_pin),
      .rif     (rif)
   );

   // ---------------------------------------------------------------
   // fixed pins and rate select
   // ---------------------------------------------------------------
   // modem status lines are simply not ports of this block
   assign dtr_out = 1'b1;
   assign rts_out = 1'b1;
   assign txd_pin = txd_ff;

   assign eff_spd = m2_ff ? SPD_9600 : spd_ff;

   always_comb begin
      if (eff_spd == SPD_38400) begin
         div_sel = DIV_HI;
      end else if (eff_spd == SPD_19200) begin
         div_sel = DIV_MID;
      end else begin
         div_sel = DIV_LO;
      end
   end

   // ---------------------------------------------------------------
   // oversample tick
   // ---------------------------------------------------------------
   // >= so a shorter divisor takes hold on the very next count
   always_comb begin
      nxt_div  = div_ff + 1'b1;
      nxt_tick = 1'b0;
      if (div_ff >= div_sel - 1'b1) begin
         nxt_div  = '0;
         nxt_tick = 1'b1;
      end
   end
   assign rif.tick = tick_ff;

   // ---------------------------------------------------------------
   // transmitter
   // ---------------------------------------------------------------
   // a queued byte starts as soon as the line is idle, no handshake
   assign f_out_ready = (tst_ff == LN_IDLE);

   always_comb begin
      nxt_tst  = tst_ff;
      nxt_tos  = tos_ff;
      nxt_tbit = tbit_ff;
      nxt_tsh  = tsh_ff;
      nxt_txd  = txd_ff;
      case (tst_ff)
         LN_IDLE: begin
            nxt_txd = 1'b1;
            if (f_out_valid) begin
               nxt_tsh = f_out_data;
               nxt_tos = '0;
               nxt_txd = 1'b0;
               nxt_tst = LN_START;
            end
         end
         LN_START: begin
            if (tick_ff) begin
               nxt_tos = tos_ff + 1'b1;
               if (tos_ff == OS_LAST) begin
                  nxt_txd  = tsh_ff[0];
                  nxt_tsh  = {1'b0, tsh_ff[7:1]};
                  nxt_tbit = '0;
                  nxt_tst  = LN_DATA;
               end
            end
         end
         LN_DATA: begin
            if (tick_ff) begin
               nxt_tos = tos_ff + 1'b1;
               if (tos_ff == OS_LAST) begin
                  nxt_tbit = tbit_ff + 1'b1;
                  nxt_txd  = tsh_ff[0];
                  nxt_tsh  = {1'b0, tsh_ff[7:1]};
                  if (tbit_ff == BIT_LAST) begin
                     nxt_txd = 1'b1;
                     nxt_tst = LN_STOP;
                  end
               end
            end
         end
         default: begin
            if (tick_ff) begin
               nxt_tos = tos_ff + 1'b1;
               if (tos_ff == OS_LAST) nxt_tst = LN_IDLE;
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // axi4-lite slave
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_got_ff;
   assign s_axi_wready  = !w_got_ff;
   assign s_axi_arready = !rv_ff;
   assign s_axi_bvalid  = bv_ff;
   assign s_axi_bresp   = br_ff;
   assign s_axi_rvalid  = rv_ff;
   assign s_axi_rresp   = rr_ff;
   assign s_axi_rdata   = rd_ff;

   assign wr_both    = aw_got_ff && w_got_ff && !bv_ff;
   assign is_tx      = (awa_ff[ADDR_W-1:2] == ADDR_TXDATA[ADDR_W-1:2]) && ws0_ff;
   // full fifo holds the write open, which stalls the master
   assign tx_stall   = is_tx && !f_in_ready;
   assign f_in_valid = wr_both && is_tx;
   assign do_wr      = wr_both && !tx_stall;
   assign do_rd      = s_axi_arvalid && !rv_ff;

   always_comb begin
      status_w                   = '0;
      status_w[ST_TX_ROOM]       = f_in_ready;
      status_w[ST_TX_BUSY]       = f_out_valid || (tst_ff != LN_IDLE);
      status_w[ST_RX_VALID]      = rxv_ff;
      status_w[ST_OVERRUN]       = ovr_ff;
      status_w[ST_FRAMING]       = fer_ff;
      status_w[ST_FIXED]         = m2_ff;
      status_w[ST_SPD_LSB +: 2]  = eff_spd;
   end

   always_comb begin
      nxt_aw_got = aw_got_ff;
      nxt_w_got  = w_got_ff;
      nxt_awa    = awa_ff;
      nxt_wd     = wd_ff;
      nxt_ws0    = ws0_ff;
      nxt_bv     = bv_ff;
      nxt_br     = br_ff;
      nxt_rv     = rv_ff;
      nxt_rr     = rr_ff;
      nxt_rd     = rd_ff;
      nxt_spd    = spd_ff;
      nxt_rxb    = rxb_ff;
      nxt_rxv    = rxv_ff;
      nxt_ovr    = ovr_ff;
      nxt_fer    = fer_ff;
      if (s_axi_awvalid && !aw_got_ff) begin
         nxt_aw_got = 1'b1;
         nxt_awa    = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_ff) begin
         nxt_w_got = 1'b1;
         nxt_wd    = s_axi_wdata;
         nxt_ws0   = s_axi_wstrb[0];
      end
      if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
      if (rv_ff && s_axi_rready) nxt_rv = 1'b0;
      if (do_wr) begin
         nxt_aw_got = 1'b0;
         nxt_w_got  = 1'b0;
         nxt_bv     = 1'b1;
         nxt_br     = RESP_OKAY;
         if (awa_ff[ADDR_W-1:2] == ADDR_TXDATA[ADDR_W-1:2]) begin
            nxt_br = RESP_OKAY;
         end else if (awa_ff[ADDR_W-1:2] == ADDR_SPEED[ADDR_W-1:2]) begin
            if (wd_ff[1:0] == SPD_BAD) begin
               nxt_br = RESP_SLVERR;
            end else if (ws0_ff) begin
               nxt_spd = hsp_speed_t'(wd_ff[1:0]);
            end
         end else if (awa_ff[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]) begin
            if (ws0_ff && wd_ff[ST_OVERRUN]) nxt_ovr = 1'b0;
            if (ws0_ff && wd_ff[ST_FRAMING]) nxt_fer = 1'b0;
         end else if (awa_ff[ADDR_W-1:2] != ADDR_RXDATA[ADDR_W-1:2]) begin
            nxt_br = RESP_SLVERR;
         end
      end
      if (do_rd) begin
         nxt_rv = 1'b1;
         nxt_rr = RESP_OKAY;
         nxt_rd = '0;
         if (s_axi_araddr[ADDR_W-1:2] == ADDR_RXDATA[ADDR_W-1:2]) begin
            nxt_rd[7:0]           = rxb_ff;
            nxt_rd[RXD_VALID_BIT] = rxv_ff;
            nxt_rxv               = 1'b0;
         end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_SPEED[ADDR_W-1:2]) begin
            nxt_rd[1:0] = spd_ff;
         end else if (s_axi_araddr[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]) begin
            nxt_rd = status_w;
         end else if (s_axi_araddr[ADDR_W-1:2] != ADDR_TXDATA[ADDR_W-1:2]) begin
            nxt_rr = RESP_SLVERR;
         end
      end
      // events after the clears so a same-cycle arrival wins
      if (rif.valid) begin
         nxt_rxb = rif.data;
         nxt_rxv = 1'b1;
         if (rxv_ff && !(do_rd && s_axi_araddr[ADDR_W-1:2] == ADDR_RXDATA[ADDR_W-1:2])) begin
            nxt_ovr = 1'b1;
         end
         if (rif.ferr) nxt_fer = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awa_ff    <= '0;
         wd_ff     <= '0;
         ws0_ff    <= 1'b0;
         bv_ff     <= 1'b0;
         br_ff     <= RESP_OKAY;
         rv_ff     <= 1'b0;
         rr_ff     <= RESP_OKAY;
         rd_ff     <= '0;
         spd_ff    <= SPEED_RST;
         rxb_ff    <= '0;
         rxv_ff    <= 1'b0;
         ovr_ff    <= 1'b0;
         fer_ff    <= 1'b0;
         m1_ff     <= 1'b0;
         m2_ff     <= 1'b0;
         div_ff    <= '0;
         tick_ff   <= 1'b0;
         tst_ff    <= LN_IDLE;
         tos_ff    <= '0;
         tbit_ff   <= '0;
         tsh_ff    <= '0;
         txd_ff    <= 1'b1;
      end else begin
         aw_got_ff <= nxt_aw_got;
         w_got_ff  <= nxt_w_got;
         awa_ff    <= nxt_awa;
         wd_ff     <= nxt_wd;
         ws0_ff    <= nxt_ws0;
         bv_ff     <= nxt_bv;
         br_ff     <= nxt_br;
         rv_ff     <= nxt_rv;
         rr_ff     <= nxt_rr;
         rd_ff     <= nxt_rd;
         spd_ff    <= nxt_spd;
         rxb_ff    <= nxt_rxb;
         rxv_ff    <= nxt_rxv;
         ovr_ff    <= nxt_ovr;
         fer_ff    <= nxt_fer;
         m1_ff     <= fixed_settings_mode;
         m2_ff     <= m1_ff;
         div_ff    <= nxt_div;
         tick_ff   <= nxt_tick;
         tst_ff    <= nxt_tst;
         tos_ff    <= nxt_tos;
         tbit_ff   <= nxt_tbit;
         tsh_ff    <= nxt_tsh;
         txd_ff    <= nxt_txd;
      end
   end
endmodule

// File: core/hsp_pkg.sv
// Purpose: constants and types shared by the host serial port files
// Assumes: 10 MHz mclk, 16x oversampling of the bit period
// Notes:   divisors round to the nearest whole clock count
package hsp_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ     = 10_000_000;
   localparam int OVS        = 16;
   localparam int BAUD_LO    = 9600;
   localparam int BAUD_MID   = 19200;
   localparam int BAUD_HI    = 38400;
   localparam int DIV_W      = 8;
   localparam logic [DIV_W-1:0] DIV_LO  = DIV_W'((CLK_HZ + BAUD_LO * OVS / 2) / (BAUD_LO * OVS));
   localparam logic [DIV_W-1:0] DIV_MID = DIV_W'((CLK_HZ + BAUD_MID * OVS / 2) / (BAUD_MID * OVS));
   localparam logic [DIV_W-1:0] DIV_HI  = DIV_W'((CLK_HZ + BAUD_HI * OVS / 2) / (BAUD_HI * OVS));
   localparam logic [3:0] OS_MID  = 4'h7;
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_TXDATA = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RXDATA = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_SPEED  = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;
   localparam int RXD_VALID_BIT = 8;
   localparam int ST_TX_ROOM  = 0;
   localparam int ST_TX_BUSY  = 1;
   localparam int ST_RX_VALID = 2;
   localparam int ST_OVERRUN  = 3;
   localparam int ST_FRAMING  = 4;
   localparam int ST_FIXED    = 5;
   localparam int ST_SPD_LSB  = 6;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int TX_FIFO_DEPTH = 4;

   typedef enum logic [1:0] {
      SPD_9600  = 2'h0,
      SPD_19200 = 2'h1,
      SPD_38400 = 2'h2,
      SPD_BAD   = 2'h3
   } hsp_speed_t;
   localparam hsp_speed_t SPEED_RST = SPD_9600;

   typedef enum logic [1:0] {
      LN_IDLE  = 2'b00,
      LN_START = 2'b01,
      LN_DATA  = 2'b10,
      LN_STOP  = 2'b11
   } hsp_line_t;
endpackage

// File: core/hsp_rx.sv
// Purpose: 16x oversampling receiver, 8N1, lsb first
// Assumes: tick is one pulse per sixteenth of a bit
// Notes:   start bit rechecked at mid-bit to reject glitches
`timescale 1ns/1ns
module hsp_rx
   import hsp_pkg::*;
(
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic rxd_pin,
   hsp_rx_if.rx      rif
);
   logic       sync1_ff, sync2_ff;
   hsp_line_t  st_ff, nxt_st;
   logic [3:0] os_ff, nxt_os;
   logic [2:0] bit_ff, nxt_bit;
   logic [7:0] sh_ff, nxt_sh;
   logic       val_ff, nxt_val, fe_ff, nxt_fe;

   assign rif.data  = sh_ff;
   assign rif.valid = val_ff;
   assign rif.ferr  = fe_ff;

   always_comb begin
      nxt_st  = st_ff;
      nxt_os  = os_ff;
      nxt_bit = bit_ff;
      nxt_sh  = sh_ff;
      nxt_val = 1'b0;
      nxt_fe  = fe_ff;
      if (rif.tick) begin
         nxt_os = os_ff + 1'b1;
         case (st_ff)
            LN_IDLE: begin
               nxt_os = '0;
               if (!sync2_ff) nxt_st = LN_START;
            end
            LN_START: begin
               if (os_ff == OS_MID) begin
                  nxt_os  = '0;
                  nxt_bit = '0;
                  nxt_st  = sync2_ff ? LN_IDLE : LN_DATA;
               end
            end
            LN_DATA: begin
               if (os_ff == OS_LAST) begin
                  nxt_sh = {sync2_ff, sh_ff[7:1]};
                  nxt_bit = bit_ff + 1'b1;
                  if (bit_ff == BIT_LAST) nxt_st = LN_STOP;
               end
            end
            default: begin
               if (os_ff == OS_LAST) begin
                  nxt_val = 1'b1;
                  nxt_fe  = !sync2_ff;
                  nxt_st  = LN_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         st_ff    <= LN_IDLE;
         os_ff    <= '0;
         bit_ff   <= '0;
         sh_ff    <= '0;
         val_ff   <= 1'b0;
         fe_ff    <= 1'b0;
      end else begin
         sync1_ff <= rxd_pin;
         sync2_ff <= sync1_ff;
         st_ff    <= nxt_st;
         os_ff    <= nxt_os;
         bit_ff   <= nxt_bit;
         sh_ff    <= nxt_sh;
         val_ff   <= nxt_val;
         fe_ff    <= nxt_fe;
      end
   end
endmodule

// File: core/hsp_rx_if.sv
// Purpose: receiver to core carrier
// Assumes: single mclk domain
// Notes:   valid is a one-cycle pulse per received character
`timescale 1ns/1ns
interface hsp_rx_if;
   logic       tick;
   logic [7:0] data;
   logic       valid;
   logic       ferr;
   modport rx   (input tick, output data, output valid, output ferr);
   modport core (output tick, input data, input valid, input ferr);
endinterface

// File: verif/hsp_assertions.sv
// Purpose: pin and bus checks for the host serial port
// Assumes: one mclk domain, async active-low reset
// Notes:   bound to every instance of the top
`timescale 1ns/1ns
module hsp_assertions
   import hsp_pkg::*;
(
   input wire logic              mclk,
   input wire logic              reset_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              txd_pin,
   input wire logic              dtr_out,
   input wire logic              rts_out
);
   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_modem_fixed: assert property (dtr_out && rts_out)
      else $error("modem outputs dropped");
   a_start_space: assert property ($fell(txd_pin) |=> !txd_pin [*8])
      else $error("start bit too short");
   a_bit_length: assert property ($changed(txd_pin) |=> $stable(txd_pin) [*8])
      else $error("serial bit too short");
   a_speed_bad: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == ADDR_SPEED && s_axi_wdata[1:0] == 2'h3 |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("bad speed code accepted");
   a_speed_good: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == ADDR_SPEED && s_axi_wdata[1:0] != 2'h3 |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY)
      else $error("speed write not answered");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
endmodule
bind hsp_host_serial_port hsp_assertions i_hsp_assertions (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd_pin, .dtr_out, .rts_out);

// File: verif/hsp_host_model.sv
// Purpose: host serial port at the far end of the line
// Assumes: 8N1 both ways, no flow control
// Notes:   bit time is set by the bench through bit_ns
`timescale 1ns/1ns
module hsp_host_model (
   input  wire logic txd_pin,
   output logic      rxd_pin
);
   int         bit_ns = 104167;
   logic [8:0] q[$];
   logic [8:0] f;
   initial rxd_pin = 1'b1;
   task automatic send(input logic [7:0] b);
      #1; // off the mclk edge
      rxd_pin = 1'b0;
      #(bit_ns);
      for (int i = 0; i < 8; i++) begin
         rxd_pin = b[i];
         #(bit_ns);
      end
      rxd_pin = 1'b1;
      #(bit_ns);
   endtask
   // centre sampling, stop bit kept in bit 8
   always begin
      @(negedge txd_pin);
      #(bit_ns / 2);
      for (int i = 0; i < 8; i++) begin
         #(bit_ns);
         f[i] = txd_pin;
      end
      #(bit_ns);
      f[8] = txd_pin;
      q.push_back(f);
   end
endmodule

// File: verif/tb_host_serial_port.sv
// Purpose: self-checking bench for the host serial port
// Assumes: 10 MHz mclk, host model at the nominal rates
// Notes:   tx and rx frames overlap to keep the run short
`timescale 1ns/1ns
module tb_host_serial_port;
   import hsp_pkg::*;
   typedef struct {logic [1:0] code; logic [1:0] resp; logic [1:0] eff; int baud;} hsp_row_t;
   logic              mclk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rxd_pin;
   logic              txd_pin, dtr_out, rts_out, fixed_settings_mode;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata, d;
   logic [1:0]        s_axi_bresp, s_axi_rresp, r;
   logic [3:0]        s_axi_wstrb = 4'hf;
   int                n_errors = 0, total_checks = 0;
   hsp_row_t          rows[4] = '{'{2'h0, RESP_OKAY, 2'h0, BAUD_LO}, '{2'h1, RESP_OKAY, 2'h1, BAUD_MID},
                                 '{2'h2, RESP_OKAY, 2'h2, BAUD_HI}, '{2'h3, RESP_SLVERR, 2'h2, BAUD_HI}};
   hsp_host_serial_port i_hsp_host_serial_port (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .rxd_pin, .txd_pin, .dtr_out, .rts_out, .fixed_settings_mode);
   hsp_host_model i_hsp_host_model (.txd_pin, .rxd_pin);
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
      @(posedge mclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h00_0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge mclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic waitq(input int n);
      for (int i = 0; i < 40000 && i_hsp_host_model.q.size() < n; i++) @(posedge mclk);
   endtask
   // one character each way at the current rate
   task automatic xfer(input logic [7:0] b);
      logic [31:0] v;
      logic [1:0]  rs;
      fork
         i_hsp_host_model.send(b);
         wr(ADDR_TXDATA, b, rs);
      join
      chk(rs, RESP_OKAY);
      waitq(1);
      chk(i_hsp_host_model.q.pop_front(), {1'b1, b});
      rd(ADDR_RXDATA, v, rs);
      chk(v, {23'h0, 1'b1, b});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      #(9_000_000);
      n_errors++;
      results();
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fixed_settings_mode} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      reset_n = 1'b0;
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      chk({dtr_out, rts_out, txd_pin}, 3'h7);
      rd(ADDR_STATUS, d, r);
      chk(d[7:6], 2'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_SPEED, {6'h0, rows[i].code}, r);
         chk(r, rows[i].resp);
         rd(ADDR_STATUS, d, r);
         chk(d[7:6], rows[i].eff);
         i_hsp_host_model.bit_ns = 1_000_000_000 / rows[i].baud;
         xfer(8'h96 ^ 8'(i));
         $display("test speed row %0d done", i);
      end
      rd(ADDR_SPEED, d, r);
      chk(d, 32'h0000_0002);
      fixed_settings_mode <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(ADDR_STATUS, d, r);
      chk(d[7:5], 3'h1);
      i_hsp_host_model.bit_ns = 1_000_000_000 / BAUD_LO;
      xfer(8'h3c);
      fixed_settings_mode <= 1'b0;
      repeat (4) @(posedge mclk);
      $display("test fixed mode done");
      i_hsp_host_model.bit_ns = 1_000_000_000 / BAUD_HI;
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_TXDATA, 8'hc0 + 8'(i), r);
         chk(r, RESP_OKAY);
      end
      rd(ADDR_STATUS, d, r);
      chk(d[1:0], 2'h2);
      waitq(6);
      for (int i = 0; i < 6; i++) chk(i_hsp_host_model.q.pop_front(), {1'b1, 8'hc0 + 8'(i)});
      $display("test burst done");
      rd(8'h10, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0000_0000);
      $display("test unmapped done");
      results();
   end
endmodule
